//--- hw/pes_top.sv
// Power event status/enable registers and system control interrupt
`timescale 1ns/1ps
`default_nettype none
module pes_top
  import pes_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Same-clock event pulses
  input wire logic timer_carry,
  input wire logic bus_master_cycle,
  input wire logic lock_release,
  // Asynchronous event pins
  input wire logic power_btn_n,
  input wire logic sleep_btn_n,
  input wire logic clock_alarm,
  input wire logic wake_done,
  input wire logic [PES_GP_W-1:0] gp_event_in,
  // Interrupt
  output logic system_control_irq
);

  // Checked while the design is built, so an oversized build never reaches silicon
  if (PES_GP_W > PES_GP_MAX) begin : g_gp_limit
    $error("too many general-purpose events");
  end

  typedef struct packed {
    logic [PES_FIX_W-1:0] fixed_event_status;
    logic [PES_FIX_W-1:0] fixed_event_enable;
    logic [PES_GP_W-1:0] gp_event_status;
    logic [PES_GP_W-1:0] gp_event_enable;
    logic irq;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] rdata;
  } pes_top_st_t;

  pes_top_st_t st_ff;
  pes_top_st_t nxt_st;

  logic [PES_ASYNC_W-1:0] sync_level;
  logic [PES_ASYNC_W-1:0] sync_rise;
  logic take;
  logic wr;
  logic [PES_FIX_W-1:0] fix_set;
  logic [PES_FIX_W-1:0] fix_clr;
  logic [PES_GP_W-1:0] gp_set;
  logic [PES_GP_W-1:0] gp_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Buttons are inverted ahead of the first stage so a press is a rise
  pes_sync_cap #(.W(PES_ASYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({gp_event_in, wake_done, clock_alarm, ~sleep_btn_n, ~power_btn_n}),
    .level(sync_level),
    .rise(sync_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and read mux

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [31:0] rd_val(input logic [7:0] a, input pes_top_st_t s);
    logic [31:0] v;
    v = 32'h00000000;
    if (hit(a, PES_FIX_STS_OFS)) v[PES_FIX_W-1:0] = s.fixed_event_status;
    if (hit(a, PES_FIX_EN_OFS)) v[PES_FIX_W-1:0] = s.fixed_event_enable;
    if (hit(a, PES_GP0_STS_OFS)) v[PES_GRP_W-1:0] = s.gp_event_status[PES_GRP_W-1:0];
    if (hit(a, PES_GP0_EN_OFS)) v[PES_GRP_W-1:0] = s.gp_event_enable[PES_GRP_W-1:0];
    if (hit(a, PES_GP1_STS_OFS)) v[PES_GRP_W-1:0] = s.gp_event_status[PES_GP_W-1:PES_GRP_W];
    if (hit(a, PES_GP1_EN_OFS)) v[PES_GRP_W-1:0] = s.gp_event_enable[PES_GP_W-1:PES_GRP_W];
    if (hit(a, PES_PEND_OFS)) begin
      v[PES_PEND_IRQ_BIT] = s.irq;
      v[PES_PEND_FIX_BIT] = |(s.fixed_event_status & s.fixed_event_enable);
      v[PES_PEND_GP_BIT] = |(s.gp_event_status & s.gp_event_enable);
    end
    rd_val = v;
  endfunction : rd_val

  ////////////////////////////////////////////////////////////////////////////
  // Event sources

  assign take = hsel & hready & htrans[1];
  // Sub-word writes are ignored; only whole words reach the registers
  assign wr = st_ff.dph & st_ff.dwr;

  always_comb begin
    fix_set = '0;
    fix_set[PES_TMR_BIT] = timer_carry;
    fix_set[PES_BM_BIT] = bus_master_cycle;
    fix_set[PES_LOCK_BIT] = lock_release;
    // A press only reports to software; there is no direct state change path
    fix_set[PES_PWR_BIT] = sync_rise[0];
    fix_set[PES_SLP_BIT] = sync_rise[1];
    fix_set[PES_ALARM_BIT] = sync_rise[2] & PES_ALARM_IMPL;
    fix_set[PES_WAKE_BIT] = sync_rise[3];
  end

  // Edge inputs latch on the rise; level inputs keep setting while held
  assign gp_set = (PES_GP_EDGE_MASK & sync_rise[PES_ASYNC_W-1:4])
                | (~PES_GP_EDGE_MASK & sync_level[PES_ASYNC_W-1:4]);

  always_comb begin
    fix_clr = '0;
    gp_clr = '0;
    if (wr && hit(st_ff.daddr, PES_FIX_STS_OFS)) fix_clr = hwdata[PES_FIX_W-1:0];
    if (wr && hit(st_ff.daddr, PES_GP0_STS_OFS)) gp_clr[PES_GRP_W-1:0] = hwdata[PES_GRP_W-1:0];
    if (wr && hit(st_ff.daddr, PES_GP1_STS_OFS)) begin
      gp_clr[PES_GP_W-1:PES_GRP_W] = hwdata[PES_GRP_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    // Set wins over a clear landing in the same cycle
    nxt_st.fixed_event_status = (st_ff.fixed_event_status & ~fix_clr) | fix_set;
    nxt_st.gp_event_status = (st_ff.gp_event_status & ~gp_clr) | gp_set;
    if (wr && hit(st_ff.daddr, PES_FIX_EN_OFS)) begin
      nxt_st.fixed_event_enable = hwdata[PES_FIX_W-1:0];
    end
    if (wr && hit(st_ff.daddr, PES_GP0_EN_OFS)) begin
      nxt_st.gp_event_enable[PES_GRP_W-1:0] = hwdata[PES_GRP_W-1:0];
    end
    if (wr && hit(st_ff.daddr, PES_GP1_EN_OFS)) begin
      nxt_st.gp_event_enable[PES_GP_W-1:PES_GRP_W] = hwdata[PES_GRP_W-1:0];
    end
    // Only the two event classes feed the shared level output
    nxt_st.irq = (|(st_ff.fixed_event_status & st_ff.fixed_event_enable))
               | (|(st_ff.gp_event_status & st_ff.gp_event_enable));
    nxt_st.dph = take;
    nxt_st.dwr = take & hwrite & (hsize == PES_HSIZE_WORD);
    nxt_st.daddr = haddr[7:0];
    // Read data comes from post-write state so a read right after a write sees it
    nxt_st.rdata = (take && !hwrite) ? rd_val(haddr[7:0], nxt_st) : 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.fixed_event_status <= PES_FIX_STS_RST;
      st_ff.fixed_event_enable <= PES_FIX_EN_RST;
      st_ff.gp_event_status <= PES_GP_STS_RST;
      st_ff.gp_event_enable <= PES_GP_EN_RST;
      st_ff.irq <= 1'b0;
      st_ff.dph <= 1'b0;
      st_ff.dwr <= 1'b0;
      st_ff.daddr <= 8'h00;
      st_ff.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign system_control_irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_fix_irq;
    (|(st_ff.fixed_event_status & st_ff.fixed_event_enable)) |=> system_control_irq;
  endproperty
  a_fix_irq: assert property (p_fix_irq) else $error("fixed event did not raise irq");

  property p_gp_irq;
    (|(st_ff.gp_event_status & st_ff.gp_event_enable)) |=> system_control_irq;
  endproperty
  a_gp_irq: assert property (p_gp_irq) else $error("gp event did not raise irq");

  property p_irq_idle;
    !(|(st_ff.fixed_event_status & st_ff.fixed_event_enable))
      && !(|(st_ff.gp_event_status & st_ff.gp_event_enable)) |=> !system_control_irq;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq high with nothing enabled");

  property p_irq_level;
    (st_ff.fixed_event_status[PES_TMR_BIT] && st_ff.fixed_event_enable[PES_TMR_BIT] && !wr)
      [*3] |=> system_control_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq dropped while held");

  property p_timer;
    timer_carry |=> st_ff.fixed_event_status[PES_TMR_BIT];
  endproperty
  a_timer: assert property (p_timer) else $error("timer carry lost");

  property p_bm;
    bus_master_cycle |=> st_ff.fixed_event_status[PES_BM_BIT];
  endproperty
  a_bm: assert property (p_bm) else $error("bus master cycle lost");

  property p_lock;
    lock_release |=> st_ff.fixed_event_status[PES_LOCK_BIT];
  endproperty
  a_lock: assert property (p_lock) else $error("lock release lost");

  property p_pwr;
    $fell(power_btn_n) ##1 (power_btn_n == 1'b0) [*4]
      |=> ##[0:2] st_ff.fixed_event_status[PES_PWR_BIT];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power button press lost");

  property p_wake;
    sync_rise[3] |=> st_ff.fixed_event_status[PES_WAKE_BIT];
  endproperty
  a_wake: assert property (p_wake) else $error("wake done lost");

  property p_slp;
    sync_rise[1] |=> st_ff.fixed_event_status[PES_SLP_BIT];
  endproperty
  a_slp: assert property (p_slp) else $error("sleep button press lost");

  property p_alarm;
    sync_rise[2] |=> st_ff.fixed_event_status[PES_ALARM_BIT];
  endproperty
  a_alarm: assert property (p_alarm) else $error("clock alarm lost");

  property p_gp_set;
    (|gp_set) |=> ((st_ff.gp_event_status & $past(gp_set)) == $past(gp_set));
  endproperty
  a_gp_set: assert property (p_gp_set) else $error("gp event not latched");

  property p_gp_clr;
    wr && hit(st_ff.daddr, PES_GP0_STS_OFS) |=>
      ((st_ff.gp_event_status[PES_GRP_W-1:0] & $past(hwdata[PES_GRP_W-1:0])
        & ~$past(gp_set[PES_GRP_W-1:0])) == '0);
  endproperty
  a_gp_clr: assert property (p_gp_clr) else $error("gp write one did not clear");

  property p_gp0_en;
    wr && hit(st_ff.daddr, PES_GP0_EN_OFS)
      |=> st_ff.gp_event_enable[PES_GRP_W-1:0] == $past(hwdata[PES_GRP_W-1:0]);
  endproperty
  a_gp0_en: assert property (p_gp0_en) else $error("gp0 enable not stored");

  property p_gp1_en;
    wr && hit(st_ff.daddr, PES_GP1_EN_OFS)
      |=> st_ff.gp_event_enable[PES_GP_W-1:PES_GRP_W] == $past(hwdata[PES_GRP_W-1:0]);
  endproperty
  a_gp1_en: assert property (p_gp1_en) else $error("gp1 enable not stored");

  property p_gp_latch;
    !wr |=> ((st_ff.gp_event_status & $past(st_ff.gp_event_status))
             == $past(st_ff.gp_event_status));
  endproperty
  a_gp_latch: assert property (p_gp_latch) else $error("gp status dropped without clear");

  property p_en_store;
    wr && hit(st_ff.daddr, PES_FIX_EN_OFS)
      |=> st_ff.fixed_event_enable == $past(hwdata[PES_FIX_W-1:0]);
  endproperty
  a_en_store: assert property (p_en_store) else $error("enable write not stored");

  property p_clr;
    wr && hit(st_ff.daddr, PES_FIX_STS_OFS) |=>
      ((st_ff.fixed_event_status & $past(hwdata[PES_FIX_W-1:0]) & ~$past(fix_set)) == '0);
  endproperty
  a_clr: assert property (p_clr) else $error("write one did not clear");

  c_irq_rise: cover property ($rose(system_control_irq));
  c_irq_fall: cover property ($fell(system_control_irq));
  c_gp_clear: cover property (wr && hit(st_ff.daddr, PES_GP0_STS_OFS) && (|gp_clr));
  c_pwr: cover property ($rose(st_ff.fixed_event_status[PES_PWR_BIT]));
  c_gp_level: cover property (|(~PES_GP_EDGE_MASK & gp_set));

endmodule : pes_top
`default_nettype wire

//--- hw/pes_pkg.sv
// Constants for the power event signalling block
package pes_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] PES_FIX_STS_OFS = 8'h00;
  localparam logic [7:0] PES_FIX_EN_OFS = 8'h04;
  localparam logic [7:0] PES_GP0_STS_OFS = 8'h08;
  localparam logic [7:0] PES_GP0_EN_OFS = 8'h0C;
  localparam logic [7:0] PES_GP1_STS_OFS = 8'h10;
  localparam logic [7:0] PES_GP1_EN_OFS = 8'h14;
  localparam logic [7:0] PES_PEND_OFS = 8'h18;

  // Widths
  localparam int PES_FIX_W = 16;
  localparam int PES_GRP_W = 16;
  localparam int PES_GP_W = 2 * PES_GRP_W;
  localparam int PES_GP_MAX = 256;
  localparam int PES_ASYNC_W = 4 + PES_GP_W;

  // Fixed event bit positions
  localparam int PES_TMR_BIT = 0;
  localparam int PES_BM_BIT = 4;
  localparam int PES_LOCK_BIT = 5;
  localparam int PES_PWR_BIT = 8;
  localparam int PES_SLP_BIT = 9;
  localparam int PES_ALARM_BIT = 10;
  localparam int PES_WAKE_BIT = 15;

  // Pending register fields
  localparam int PES_PEND_IRQ_BIT = 0;
  localparam int PES_PEND_FIX_BIT = 1;
  localparam int PES_PEND_GP_BIT = 2;

  // Build options: alarm status present, per-input trigger type (1 = edge)
  localparam logic PES_ALARM_IMPL = 1'b1;
  localparam logic [PES_GP_W-1:0] PES_GP_EDGE_MASK = 32'h0000FFFF;

  // Reset values
  localparam logic [PES_FIX_W-1:0] PES_FIX_STS_RST = 16'h0000;
  localparam logic [PES_FIX_W-1:0] PES_FIX_EN_RST = 16'h0000;
  localparam logic [PES_GP_W-1:0] PES_GP_STS_RST = 32'h00000000;
  localparam logic [PES_GP_W-1:0] PES_GP_EN_RST = 32'h00000000;

  // AHB encodings
  localparam logic [2:0] PES_HSIZE_WORD = 3'h2;

endpackage : pes_pkg

//--- hw/pes_sync_cap.sv
// Three-stage input synchroniser with qualified level and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pes_sync_cap
  import pes_pkg::*;
#(
  parameter int W = PES_ASYNC_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw pins
  input wire logic [W-1:0] async_in,
  // Qualified outputs
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] prv;
  } pes_sync_st_t;

  pes_sync_st_t st_ff;
  pes_sync_st_t nxt_st;

  // A change is accepted only once stages two and three agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lvl = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.lvl);
    nxt_st.prv = st_ff.lvl;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.lvl;
  assign rise = st_ff.lvl & ~st_ff.prv;

endmodule : pes_sync_cap
`default_nettype wire

//--- bench/pes_tb.sv
// Self-checking bench for the power event signalling block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pes_pkg::*;
();
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, system_control_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic timer_carry, bus_master_cycle, lock_release;
  logic power_btn_n, sleep_btn_n, clock_alarm, wake_done;
  logic [PES_GP_W-1:0] gp_event_in;
  logic [31:0] exp_sts;
  int n_errors = 0;
  int checked = 0;
  int fbit [7] = '{PES_TMR_BIT, PES_BM_BIT, PES_LOCK_BIT, PES_PWR_BIT, PES_SLP_BIT,
                   PES_ALARM_BIT, PES_WAKE_BIT};

  pes_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_carry(timer_carry), .bus_master_cycle(bus_master_cycle),
    .lock_release(lock_release), .power_btn_n(power_btn_n), .sleep_btn_n(sleep_btn_n),
    .clock_alarm(clock_alarm), .wake_done(wake_done), .gp_event_in(gp_event_in),
    .system_control_irq(system_control_irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic irq_is(input string nm, input logic v);
    chk(nm, {31'h0, v}, {31'h0, system_control_irq});
  endtask : irq_is

  // Address phase held until hready is seen high at a rising edge
  task automatic addr_ph(input logic [7:0] a, input logic w, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
  endtask : addr_ph

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [2:0] sz = PES_HSIZE_WORD);
    addr_ph(a, 1'b1, sz);
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wr

  // Read data is taken at the edge that closes the data phase
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    addr_ph(a, 1'b0, PES_HSIZE_WORD);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    chk(nm, e, hrdata);
  endtask : rdc

  task automatic drive(input int i, input logic v);
    case (i)
      0: timer_carry <= v;
      1: bus_master_cycle <= v;
      2: lock_release <= v;
      3: power_btn_n <= !v;
      4: sleep_btn_n <= !v;
      5: clock_alarm <= v;
      default: wake_done <= v;
    endcase
  endtask : drive

  // Same-clock sources pulse one cycle; pins are held long enough to pass the synchroniser
  task automatic fire(input int i);
    drive(i, 1'b1);
    repeat (i < 3 ? 1 : 8) @(posedge hclk);
    drive(i, 1'b0);
    repeat (8) @(posedge hclk);
  endtask : fire

  task automatic gp_pin(input int i, input logic v);
    gp_event_in[i] <= v;
    repeat (8) @(posedge hclk);
  endtask : gp_pin

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    end_sim();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = PES_HSIZE_WORD;
    hwdata = 32'h0;
    {timer_carry, bus_master_cycle, lock_release, clock_alarm, wake_done} = 5'h00;
    {power_btn_n, sleep_btn_n} = 2'h3;
    gp_event_in = '0;
    repeat (4) @(posedge hclk);
    irq_is("irq in reset", 1'b0);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    for (int a = 0; a <= 28; a += 4) rdc("reset value", 8'(a), 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    // Every fixed source with enables off: status accumulates, interrupt stays low
    exp_sts = 32'h0;
    for (int i = 0; i < 7; i++) begin
      fire(i);
      exp_sts[fbit[i]] = 1'b1;
      rdc("fixed status", PES_FIX_STS_OFS, exp_sts);
      irq_is("irq masked", 1'b0);
    end
    wr(PES_FIX_EN_OFS, exp_sts);
    rdc("fixed enable", PES_FIX_EN_OFS, exp_sts);
    wr(PES_FIX_EN_OFS, 32'h0, 3'h0);
    rdc("byte write", PES_FIX_EN_OFS, exp_sts);
    repeat (3) @(posedge hclk);
    irq_is("irq fixed", 1'b1);
    rdc("pending fixed", PES_PEND_OFS, 32'h3);
    wr(PES_FIX_STS_OFS, 32'h0);
    rdc("zero write", PES_FIX_STS_OFS, exp_sts);
    wr(PES_FIX_STS_OFS, exp_sts & ~32'h1);
    rdc("one clears", PES_FIX_STS_OFS, 32'h1);
    repeat (3) @(posedge hclk);
    irq_is("irq held", 1'b1);
    wr(PES_FIX_STS_OFS, 32'h1);
    repeat (3) @(posedge hclk);
    irq_is("irq released", 1'b0);
    // Group zero input is edge triggered and latches
    wr(PES_GP0_EN_OFS, 32'h8);
    rdc("gp0 enable", PES_GP0_EN_OFS, 32'h8);
    gp_pin(3, 1'b1);
    gp_pin(3, 1'b0);
    rdc("gp0 latched", PES_GP0_STS_OFS, 32'h8);
    irq_is("irq gp0", 1'b1);
    rdc("pending gp", PES_PEND_OFS, 32'h5);
    // Software masks the event before servicing it; the status stays latched
    wr(PES_GP0_EN_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    irq_is("irq gp0 masked", 1'b0);
    rdc("gp0 held masked", PES_GP0_STS_OFS, 32'h8);
    wr(PES_GP0_EN_OFS, 32'h8);
    gp_pin(3, 1'b1);
    wr(PES_GP0_STS_OFS, 32'h8);
    repeat (2) @(posedge hclk);
    rdc("gp0 edge clear", PES_GP0_STS_OFS, 32'h0);
    gp_pin(3, 1'b0);
    irq_is("irq gp0 off", 1'b0);
    // Group one input is level triggered: a clear does not stick while the pin is high
    wr(PES_GP1_EN_OFS, 32'h4);
    gp_pin(18, 1'b1);
    rdc("gp1 level", PES_GP1_STS_OFS, 32'h4);
    irq_is("irq gp1", 1'b1);
    wr(PES_GP1_STS_OFS, 32'h4);
    repeat (2) @(posedge hclk);
    rdc("gp1 reset", PES_GP1_STS_OFS, 32'h4);
    gp_pin(18, 1'b0);
    wr(PES_GP1_STS_OFS, 32'h4);
    repeat (3) @(posedge hclk);
    rdc("gp1 cleared", PES_GP1_STS_OFS, 32'h0);
    irq_is("irq gp1 off", 1'b0);
    // Unmapped and read-only places ignore writes
    wr(8'h1C, 32'hFFFF);
    rdc("unmapped", 8'h1C, 32'h0);
    wr(PES_PEND_OFS, 32'h7);
    rdc("pending ro", PES_PEND_OFS, 32'h0);
    // Reset in mid-run drops the interrupt at once and empties the registers
    wr(PES_FIX_EN_OFS, 32'h1);
    fire(0);
    irq_is("irq before reset", 1'b1);
    hresetn <= 1'b0;
    @(posedge hclk);
    irq_is("irq mid reset", 1'b0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc("status after reset", PES_FIX_STS_OFS, 32'h0);
    rdc("enable after reset", PES_FIX_EN_OFS, 32'h0);
    irq_is("irq after reset", 1'b0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
